// file: shared/adcc_defs.vh
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ADCC_OFS_CTRL    4'h0
`define ADCC_OFS_CLKSET  4'h1
`define ADCC_OFS_RESLO   4'h2
`define ADCC_OFS_RESHI   4'h3
`define ADCC_OFS_STATUS  4'h4
`define ADCC_OFS_MASK    4'h5
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define ADCC_CTRL_CHAN_LSB  0
`define ADCC_CTRL_CHAN_MSB  2
`define ADCC_CTRL_PCFG_LSB  3
`define ADCC_CTRL_PCFG_MSB  5
`define ADCC_CTRL_PEND      6
`define ADCC_CTRL_START     7
// ----------------------------------------
// Clock setup register fields
// ----------------------------------------
`define ADCC_CLK_DIV_LSB  0
`define ADCC_CLK_DIV_MSB  2
`define ADCC_CLK_PDN      7
// ----------------------------------------
// Divider codes and ratios
// ----------------------------------------
`define ADCC_DIV_CODE2    3'h0
`define ADCC_DIV_CODE8    3'h1
`define ADCC_DIV_CODE32   3'h2
`define ADCC_HALF2        5'h00
`define ADCC_HALF8        5'h03
`define ADCC_HALF32       5'h0f
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define ADCC_CTRL_RESET    8'h00
`define ADCC_CLKSET_RESET  8'h80
`define ADCC_CONV_PERIODS  5'h10
`define ADCC_NUM_CHAN      6
`endif

// file: rtl/adcc_conversion_control.v
`timescale 1ns/100ps
`include "adcc_defs.vh"
// What this block does
// - Result high register holds D11..D4
// - Result low bits 7..4 hold D3..D0
// - Channel select routes one of six inputs
// - Zero pin config: pins I/O, converter off
// - Start low-high-low pulse begins conversion
// - Start high: converter reset, pending forced high
// - Pending flag self-clears after conversion ends
// - Conversion end sets interrupt flag, enable gated
// - Divider codes 2, 8, 32; code 3 undefined
// - Converter on when config nonzero, not powered down
// - Conversion lasts sixteen converter clock periods
module adcc_conversion_control #(
  parameter DATA_W = 12
) (
  // System
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [3:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Analog front end
  input  wire [DATA_W-1:0] conv_data_i,
  output reg  [2:0]        channel_select_o,
  output reg  [5:0]        analog_input_pins_o,
  output reg               converter_enable_o,
  output reg               converter_reset_o,
  output reg               converter_clk_o,
  // Interrupt
  output reg               irq_o
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [2:0]        channel_select;
  reg  [2:0]        pin_configuration_field;
  reg               start_bit;
  reg               conversion_pending_flag;
  reg  [2:0]        clock_divider_select;
  reg               converter_power_down;
  reg  [DATA_W-1:0] result;
  reg               irq_status;
  reg               irq_mask;
  reg               start_q;
  reg  [4:0]        div_cnt;
  reg               conv_clk;
  reg  [4:0]        period_cnt;
  reg               converting;
  reg               conv_data_valid_q;

  wire       wr_stb  = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
  wire       rd_stb  = cyc_i & stb_i & ~we_i & ~ack_o;
  wire       conv_on = (pin_configuration_field != 3'h0) & ~converter_power_down;
  wire       start_rise = start_bit & ~start_q;
  wire       start_fall = ~start_bit & start_q;
  wire       wr_ctrl = wr_stb & (adr_i == `ADCC_OFS_CTRL);

  // Half-period of the divided clock for a divider code
  function [4:0] half_count;
    input [2:0] code;
    begin
      case (code)
        `ADCC_DIV_CODE2:  half_count = `ADCC_HALF2;
        `ADCC_DIV_CODE8:  half_count = `ADCC_HALF8;
        `ADCC_DIV_CODE32: half_count = `ADCC_HALF32;
        // Undefined codes fall back to the slowest ratio
        default:          half_count = `ADCC_HALF32;
      endcase
    end
  endfunction

  wire [4:0] half_lim = half_count(clock_divider_select);
  wire       tick_rise = (div_cnt == half_lim) & ~conv_clk;
  wire       conv_done = converting & tick_rise & (period_cnt == `ADCC_CONV_PERIODS - 5'h01);

  // ----------------------------------------
  // Register writes and start sequencing
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      channel_select          <= 3'h0;
      pin_configuration_field <= 3'h0;
      start_bit               <= 1'b0;
      start_q                 <= 1'b0;
      clock_divider_select    <= 3'h0;
      converter_power_down    <= 1'b1;
      conversion_pending_flag <= 1'b0;
      irq_status              <= 1'b0;
      irq_mask                <= 1'b0;
    end else if (ce_i) begin
      start_q <= start_bit;
      if (wr_ctrl) begin
        channel_select          <= dat_i[`ADCC_CTRL_CHAN_MSB:`ADCC_CTRL_CHAN_LSB];
        pin_configuration_field <= dat_i[`ADCC_CTRL_PCFG_MSB:`ADCC_CTRL_PCFG_LSB];
        start_bit               <= dat_i[`ADCC_CTRL_START];
      end
      if (wr_stb && adr_i == `ADCC_OFS_CLKSET) begin
        clock_divider_select <= dat_i[`ADCC_CLK_DIV_MSB:`ADCC_CLK_DIV_LSB];
        converter_power_down <= dat_i[`ADCC_CLK_PDN];
      end
      if (wr_stb && adr_i == `ADCC_OFS_MASK)
        irq_mask <= dat_i[0];
      // Pending set while the start bit is high dominates any clear
      if (start_rise || start_bit)
        conversion_pending_flag <= 1'b1;
      else if (conv_done)
        conversion_pending_flag <= 1'b0;
      // Set wins over the write-one clear
      if (conv_done)
        irq_status <= 1'b1;
      else if (wr_stb && adr_i == `ADCC_OFS_STATUS && dat_i[0])
        irq_status <= 1'b0;
    end
  end

  // ----------------------------------------
  // Converter clock divider
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt  <= 5'h00;
      conv_clk <= 1'b0;
    end else if (ce_i) begin
      if (!conv_on) begin
        div_cnt  <= 5'h00;
        conv_clk <= 1'b0;
      end else if (div_cnt == half_lim) begin
        div_cnt  <= 5'h00;
        conv_clk <= ~conv_clk;
      end else begin
        div_cnt <= div_cnt + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      converting        <= 1'b0;
      period_cnt        <= 5'h00;
      result            <= {DATA_W{1'b0}};
      conv_data_valid_q <= 1'b0;
    end else if (ce_i) begin
      conv_data_valid_q <= conv_done;
      if (start_bit || !conv_on) begin
        // Held in reset while start stays high or power is off
        converting <= 1'b0;
        period_cnt <= 5'h00;
      end else if (start_fall) begin
        converting <= 1'b1;
        period_cnt <= 5'h00;
      end else if (converting && tick_rise) begin
        if (conv_done) begin
          converting <= 1'b0;
          result     <= conv_data_i;
        end else begin
          period_cnt <= period_cnt + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // Wishbone read and outputs
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o               <= 1'b0;
      dat_o               <= 32'h0000_0000;
      channel_select_o    <= 3'h0;
      analog_input_pins_o <= 6'h00;
      converter_enable_o  <= 1'b0;
      converter_reset_o   <= 1'b1;
      converter_clk_o     <= 1'b0;
      irq_o               <= 1'b0;
    end else if (ce_i) begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= 32'h0000_0000;
      if (rd_stb) begin
        case (adr_i)
          `ADCC_OFS_CTRL:   dat_o[7:0] <= {start_bit, conversion_pending_flag,
                                           pin_configuration_field, channel_select};
          `ADCC_OFS_CLKSET: dat_o[7:0] <= {converter_power_down, 4'h0, clock_divider_select};
          `ADCC_OFS_RESLO:  dat_o[7:0] <= {result[3:0], 4'h0};
          `ADCC_OFS_RESHI:  dat_o[7:0] <= result[DATA_W-1:4];
          `ADCC_OFS_STATUS: dat_o[7:0] <= {7'h00, irq_status};
          `ADCC_OFS_MASK:   dat_o[7:0] <= {7'h00, irq_mask};
          default:          dat_o[7:0] <= 8'h00;
        endcase
      end
      channel_select_o   <= channel_select;
      converter_enable_o <= conv_on;
      converter_reset_o  <= start_bit | ~conv_on;
      converter_clk_o    <= conv_clk;
      irq_o              <= (irq_status | conv_done) & irq_mask;
    end
  end

  // Pin analog mode: first N pins for nonzero configuration codes
  genvar gi;
  generate
    for (gi = 0; gi < `ADCC_NUM_CHAN; gi = gi + 1) begin : g_pin
      always @(posedge clk_i) begin
        if (rst_i)
          analog_input_pins_o[gi] <= 1'b0;
        else if (ce_i)
          analog_input_pins_o[gi] <= (pin_configuration_field > gi);
      end
    end
  endgenerate

endmodule // adcc_conversion_control

// file: tb/adcc_assertions.sv
`timescale 1ns/100ps
module adcc_checker #(
  parameter DATA_W = 12
) (
  // System
  input logic        clk_i,
  input logic        rst_i,
  // Bus
  input logic        we_i,
  input logic [3:0]  adr_i,
  input logic [31:0] dat_o,
  input logic        ack_o,
  // Converter side
  input logic [5:0]  analog_input_pins_o,
  input logic        converter_enable_o,
  input logic        converter_reset_o,
  input logic        converter_clk_o,
  input logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_lo_nibble_zero: assert property (ack_o && $past(adr_i == 4'h2 && !we_i) |-> dat_o[3:0] == 4'h0)
    else $error("result low nibble not zero");
  a_byte_wide_read: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("read data above byte not zero");
  a_pins_thermo: assert property ((analog_input_pins_o & (analog_input_pins_o + 6'h01)) == 6'h00)
    else $error("pin map not contiguous from pin zero");
  a_no_pins_off: assert property (analog_input_pins_o == 6'h00 |-> !converter_enable_o)
    else $error("converter on with no analog pins");
  a_off_in_reset: assert property (!converter_enable_o |-> converter_reset_o)
    else $error("converter off but not held in reset");
  a_clk_idle_off: assert property (!converter_enable_o [*2] |-> !converter_clk_o)
    else $error("converter clock runs while off");
  a_clk_high_bound: assert property ($rose(converter_clk_o) |-> ##[1:16] !converter_clk_o)
    else $error("converter clock high too long");
  a_reset_state: assert property (disable iff (1'b0) rst_i |=> converter_reset_o && !converter_enable_o && !irq_o)
    else $error("outputs wrong after reset");
endmodule // adcc_checker

bind adcc_conversion_control adcc_checker #(.DATA_W(DATA_W)) u_adcc_checker (.clk_i, .rst_i, .we_i, .adr_i,
  .dat_o, .ack_o, .analog_input_pins_o, .converter_enable_o, .converter_reset_o, .converter_clk_o, .irq_o);

// file: tb/adcc_analog_src.sv
`timescale 1ns/100ps
module adcc_analog_src (
  // Converter side
  input  logic        clk_i,
  input  logic [2:0]  channel_select_i,
  input  logic        enable_i,
  output logic [11:0] sample_o
);
  logic [11:0] idle = 12'h5a5;
  always @(posedge clk_i) idle <= ~idle;
  // Unpowered front end floats: never a stale value
  assign sample_o = enable_i ? {channel_select_i, 9'h1c3} : idle;
endmodule // adcc_analog_src

// file: tb/adcc_conversion_control_tb.sv
`timescale 1ns/100ps
module adcc_conversion_control_tb;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        ce = 1;
  logic        cyc_i = 0;
  logic        stb_i = 0;
  logic        we_i = 0;
  logic [3:0]  adr_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rd;
  logic        ack_o, en, rs, ck, irq_o;
  logic [11:0] conv;
  logic [2:0]  chan;
  logic [5:0]  pins;
  logic [3:0]  ra [5] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h9};
  logic [7:0]  rv [5] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
  int          error_cnt = 0, tests_run = 0, cyc = 0;
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  adcc_conversion_control u_adcc_conversion_control (.clk_i, .rst_i, .ce_i(ce), .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i(4'h1), .dat_i, .dat_o, .ack_o, .conv_data_i(conv), .channel_select_o(chan), .analog_input_pins_o(pins),
    .converter_enable_o(en), .converter_reset_o(rs), .converter_clk_o(ck), .irq_o);
  adcc_analog_src u_adcc_analog_src (.clk_i, .channel_select_i(chan), .enable_i(en), .sample_o(conv));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n == 20) chk(0, 1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic t_reset;
    chk({en, rs, irq_o}, 3'b010);
    wb(1, 4'h9, 8'hff);
    foreach (ra[i]) begin
      wb(0, ra[i], 8'h00);
      chk(rd, rv[i]);
    end
  endtask
  task automatic t_power;
    wb(1, 4'h1, 8'h01);
    for (int p = 0; p < 8; p++) begin
      wb(1, 4'h0, {2'b00, p[2:0], 3'h0});
      repeat (2) @(posedge clk_i);
      chk(en, p != 0);
      chk(pins, ((8'h1 << p) - 8'h1) & 8'h3f);
    end
    wb(1, 4'h1, 8'h81);
    repeat (2) @(posedge clk_i);
    chk({en, rs}, 2'b01);
  endtask
  // Every divider code checks timing, channel, interrupt and result; accuracy is not modelled
  task automatic t_conv(input logic [2:0] ch, input logic [2:0] code, input logic msk);
    int t, n, dv;
    dv = (code == 3'h0) ? 2 : (code == 3'h1) ? 8 : 32;
    n = 0;
    wb(1, 4'h5, {7'h0, msk});
    wb(1, 4'h1, {5'h0, code});
    wb(1, 4'h0, {2'b00, 3'h6, ch});
    wb(1, 4'h0, {2'b10, 3'h6, ch});
    wb(0, 4'h0, 8'h00);
    chk({rd[7:6], rs}, 3'b111);
    wb(1, 4'h0, {2'b00, 3'h6, ch});
    t = cyc;
    do begin
      wb(0, 4'h0, 8'h00);
      n++;
    end while (rd[6] !== 1'b0 && n < 400);
    t = cyc - t;
    chk(t >= 15 * dv && t <= 17 * dv + 8, 1);
    chk(chan, ch);
    repeat (2) @(posedge clk_i);
    chk({irq_o, rs}, {msk, 1'b0});
    wb(0, 4'h4, 8'h00);
    chk(rd, 1);
    wb(1, 4'h3, 8'hff);
    wb(0, 4'h3, 8'h00);
    chk(rd, {ch, 5'h1c});
    wb(0, 4'h2, 8'h00);
    chk(rd, 8'h30);
    wb(1, 4'h4, 8'h01);
    wb(0, 4'h4, 8'h00);
    chk({rd[0], irq_o}, 2'b00);
  endtask
  // Request held while the clock enable is low must not be answered
  task automatic t_freeze;
    int n;
    n = 0;
    @(posedge clk_i);
    ce    <= 1'b0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= 1'b0;
    adr_i <= 4'h4;
    repeat (3) @(posedge clk_i);
    chk(ack_o, 0);
    ce <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    chk(ack_o, 1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_power();
    t_conv(3'h0, 3'h0, 1'b1);
    t_conv(3'h5, 3'h1, 1'b1);
    t_conv(3'h2, 3'h2, 1'b0);
    t_conv(3'h3, 3'h3, 1'b1);
    t_freeze();
    stop_test();
  end
endmodule // adcc_conversion_control_tb
